// ### hw/nph_host.sv
// Summary of operation
// - read: 00h, five address, 30h
// - each read strobe fetches next byte
// - at most four partial programs per page; the count restarts whenever another page is programmed
// - program pages in ascending order; checked only against the last page programmed, when in the same block
// - program: 80h, address, data, 10h
// - copy read: 35h confirm, buffer readable
// - copy program: 85h, address, 10h
// - copy source and destination same plane
// - id: 90h, one zero address, five reads
module nph_host
  import nph_pkg::*;
#(
  parameter int BUSY_LIMIT = 100000,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic     core_clk,  // system clock
  input  wire logic     rst,       // synchronous reset
  input  wire logic     cmd_valid, // user command offered
  output logic          cmd_ready, // controller idle
  input  wire nph_cmd_t cmd,       // command fields
  input  wire logic     wr_valid,  // program byte offered
  output logic          wr_ready,  // fifo has room
  input  wire logic [7:0] wr_data, // program byte
  output logic          rd_valid,  // read byte pulse
  output logic    [7:0] rd_data,   // read byte
  output nph_rsp_t      rsp,       // completion report
  output nph_pins_t     pins,      // flash pin drive
  input  wire logic [7:0] dq_i,    // flash data in
  input  wire logic     rb_n       // ready high, busy low
);
  typedef enum {S_IDLE, S_CMD1, S_ADDR, S_CMD2, S_GAP, S_BUSY, S_WR, S_RD, S_DONE} nph_st_t;

  nph_st_t     st_q, st_d;
  nph_cmd_t    cur_q, cur_d;
  nph_pins_t   pin_q, pin_d;
  nph_rsp_t    rsp_q, rsp_d;
  nph_tmr_t    tmr_q, tmr_d;
  logic        ph_q, ph_d, ready_q, ready_d, rdv_q, rdv_d, stat_q, stat_d;
  logic        rdmode_q, rdmode_d, load_q, load_d, cpsrc_q, cpsrc_d;
  logic [2:0]  acnt_q, acnt_d, pcnt_q, pcnt_d;
  logic [11:0] bcnt_q, bcnt_d;
  logic [7:0]  rdat_q, rdat_d, wdat_q, wdat_d;
  logic [16:0] lrow_q, lrow_d, srow_q, srow_d;
  logic        f_valid, f_pop, accept, refuse, bend, lend, last_byte;
  logic [7:0]  f_data;
  logic [2:0]  nadr;

  nph_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  function automatic logic [7:0] first_byte(nph_op_t op);
    case (op)
      OP_READ, OP_CPREAD: first_byte = CB_READ1;
      OP_ROUT:            first_byte = CB_ROUT1;
      OP_PROG:            first_byte = CB_PROG1;
      OP_CPPROG, OP_RIN:  first_byte = CB_RIN;
      OP_CONFIRM:         first_byte = CB_PROG2;
      OP_STATUS:          first_byte = CB_STATUS;
      OP_ID:              first_byte = CB_ID;
      default:            first_byte = CB_RESET;
    endcase
  endfunction : first_byte

  function automatic logic [7:0] addr_byte(nph_cmd_t c, logic [2:0] i);
    case (i)
      3'h0:    addr_byte = (c.op == OP_ID) ? ID_ADDR : c.col[7:0];
      3'h1:    addr_byte = {4'h0, c.col[11:8]};
      3'h2:    addr_byte = c.row[7:0];
      3'h3:    addr_byte = c.row[15:8];
      default: addr_byte = {7'h00, c.row[16]};
    endcase
  endfunction : addr_byte

  always_comb begin
    st_d = st_q;   cur_d = cur_q;   tmr_d = tmr_q;   ph_d = ph_q;
    acnt_d = acnt_q;   bcnt_d = bcnt_q;   rdat_d = rdat_q;   wdat_d = wdat_q;
    rdmode_d = rdmode_q;   load_d = load_q;   cpsrc_d = cpsrc_q;   stat_d = stat_q;
    pcnt_d = pcnt_q;   lrow_d = lrow_q;   srow_d = srow_q;
    rsp_d = '{done: 1'b0, err: 1'b0, fail: rsp_q.fail, status: rsp_q.status};
    rdv_d = 1'b0;
    f_pop = 1'b0;
    accept = cmd_valid && ready_q && st_q == S_IDLE;
    case (cur_q.op)
      OP_ROUT, OP_RIN: nadr = COL_CYC;
      OP_ID:           nadr = ID_CYC;
      default:         nadr = ADDR_CYC;
    endcase
    refuse = 1'b0;
    case (cmd.op)
      OP_ROUT:    refuse = !rdmode_q;
      OP_RIN:     refuse = !load_q;
      OP_CONFIRM: refuse = !load_q;
      OP_CPPROG:  refuse = !cpsrc_q || cmd.row[PLANE_BIT] != srow_q[PLANE_BIT];
      OP_PROG:    refuse = (cmd.row == lrow_q) ? (pcnt_q == PART_MAX) :
                  (cmd.row[16:PAGE_BITS] == lrow_q[16:PAGE_BITS] && pcnt_q != 3'h0 &&
                   cmd.row[PAGE_BITS-1:0] < lrow_q[PAGE_BITS-1:0]);
      default:    refuse = 1'b0;
    endcase
    // byte engine: strobe low for STB_CYC, high for STB_CYC
    bend = ph_q && tmr_q == STB_CYC - 1'b1;
    lend = !ph_q && tmr_q == STB_CYC - 1'b1;
    last_byte = bcnt_q == cur_q.len - 1'b1;
    pin_d = pin_q;
    pin_d.ce_n = st_q == S_IDLE || st_q == S_DONE;
    pin_d.wp_n = 1'b1;
    pin_d.cle = st_q == S_CMD1 || st_q == S_CMD2;
    pin_d.ale = st_q == S_ADDR;
    pin_d.we_n = 1'b1;
    pin_d.read_strobe_n = 1'b1;
    pin_d.dq_oe = st_q == S_CMD1 || st_q == S_CMD2 || st_q == S_ADDR || st_q == S_WR;
    if (st_q inside {S_CMD1, S_CMD2, S_ADDR, S_WR, S_RD}) begin
      tmr_d = (lend || bend) ? '0 : tmr_q + 1'b1;
      ph_d  = lend ? 1'b1 : (bend ? 1'b0 : ph_q);
    end
    case (st_q)
      S_IDLE: begin
        tmr_d = '0;
        ph_d = 1'b0;
        if (accept) begin
          cur_d = cmd;
          acnt_d = '0;
          bcnt_d = '0;
          stat_d = 1'b0;
          if (refuse) begin
            rsp_d.err = 1'b1;
            st_d = S_DONE;
          end else begin
            st_d = S_CMD1;
            if (cmd.op == OP_ID) cur_d.len = ID_BYTES;
            if (cmd.op == OP_STATUS) cur_d.len = 12'h001;
            if (cmd.op == OP_PROG) begin
              pcnt_d = (cmd.row == lrow_q) ? pcnt_q + 1'b1 : 3'h1;
              lrow_d = cmd.row;
            end
            if (cmd.op == OP_CPREAD) srow_d = cmd.row;
            load_d = cmd.op inside {OP_PROG, OP_CPPROG, OP_RIN};
            rdmode_d = cmd.op inside {OP_ROUT} ? rdmode_q : 1'b0;
            if (cmd.op inside {OP_READ, OP_RESET}) cpsrc_d = 1'b0;
          end
        end
      end
      S_CMD1, S_CMD2: begin
        pin_d.dq_o = (st_q == S_CMD1) ? first_byte(cur_q.op) :
                     (cur_q.op == OP_READ) ? CB_READ2 :
                     (cur_q.op == OP_CPREAD) ? CB_CPREAD2 : CB_ROUT2;
        pin_d.we_n = ph_q;
        if (bend) begin
          if (st_q == S_CMD2) begin
            st_d = (cur_q.op == OP_ROUT) ? S_GAP : S_BUSY;
          end else begin
            case (cur_q.op)
              OP_CONFIRM, OP_RESET: st_d = S_BUSY;
              OP_STATUS:            st_d = S_GAP;
              default:              st_d = S_ADDR;
            endcase
          end
        end
      end
      S_ADDR: begin
        pin_d.dq_o = addr_byte(cur_q, (cur_q.op == OP_ROUT || cur_q.op == OP_RIN) ?
                               acnt_q : ((nadr == ID_CYC) ? 3'h0 : acnt_q));
        pin_d.we_n = ph_q;
        if (bend) begin
          acnt_d = acnt_q + 1'b1;
          if (acnt_q == nadr - 1'b1) begin
            if (cur_q.op inside {OP_READ, OP_CPREAD, OP_ROUT}) st_d = S_CMD2;
            else st_d = S_GAP;
          end
        end
      end
      S_GAP: begin
        tmr_d = tmr_q + 1'b1;
        if (tmr_q == WHR_CYC - 1'b1) begin
          tmr_d = '0;
          if (cur_q.op inside {OP_PROG, OP_CPPROG, OP_RIN})
            st_d = (cur_q.len == '0) ? S_DONE : S_WR;
          else st_d = S_RD;
        end
      end
      S_BUSY: begin
        tmr_d = tmr_q + 1'b1;
        if (tmr_q >= WB_CYC && rb_n) begin
          tmr_d = '0;
          case (cur_q.op)
            OP_CONFIRM: begin
              load_d = 1'b0;
              stat_d = 1'b1;
              cur_d.op = OP_STATUS;
              cur_d.len = 12'h001;
              st_d = S_CMD1;
            end
            OP_READ, OP_CPREAD: begin
              rdmode_d = 1'b1;
              cpsrc_d = cur_q.op == OP_CPREAD;
              st_d = (cur_q.len == '0) ? S_DONE : S_RD;
            end
            default: st_d = S_DONE;
          endcase
        end else if (tmr_q >= ((cur_q.op inside {OP_READ, OP_CPREAD}) ?
                                LOAD_CYC + WB_CYC : nph_tmr_t'(BUSY_LIMIT))) begin
          rsp_d.err = 1'b1;
          load_d = 1'b0;
          st_d = S_DONE;
        end
      end
      S_WR: begin
        if (!ph_q && tmr_q == '0) begin
          if (f_valid) begin
            f_pop = 1'b1;
            wdat_d = f_data;
          end else begin
            tmr_d = '0;                                                 // stall on empty fifo
          end
        end
        pin_d.dq_o = f_pop ? f_data : wdat_q;
        pin_d.we_n = ph_q || (tmr_q == '0 && !f_valid);
        if (bend) begin
          bcnt_d = bcnt_q + 1'b1;
          if (last_byte) st_d = S_DONE;
        end
      end
      S_RD: begin
        pin_d.read_strobe_n = ph_q;
        if (ph_q && tmr_q == '0) begin
          rdat_d = dq_i;
          rdv_d = !stat_q;
          if (cur_q.op == OP_STATUS) rsp_d.status = dq_i;
          if (stat_q) rsp_d.fail = dq_i[0];
        end
        if (bend) begin
          bcnt_d = bcnt_q + 1'b1;
          if (last_byte) st_d = S_DONE;
        end
      end
      S_DONE: begin
        rsp_d.done = 1'b1;
        rsp_d.err = rsp_q.err;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
    ready_d = st_d == S_IDLE && !(st_q == S_IDLE && accept);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= S_IDLE;   cur_q <= '0;   tmr_q <= '0;   ph_q <= 1'b0;
      acnt_q <= '0;   bcnt_q <= '0;   rdat_q <= '0;   wdat_q <= '0;
      rdmode_q <= 1'b0;   load_q <= 1'b0;   cpsrc_q <= 1'b0;   stat_q <= 1'b0;
      pcnt_q <= '0;   lrow_q <= '0;   srow_q <= '0;   ready_q <= 1'b0;   rdv_q <= 1'b0;
      rsp_q <= '0;
      pin_q <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1,
                 wp_n: 1'b1, dq_oe: 1'b0, dq_o: 8'h00};
    end else begin
      st_q <= st_d;   cur_q <= cur_d;   tmr_q <= tmr_d;   ph_q <= ph_d;
      acnt_q <= acnt_d;   bcnt_q <= bcnt_d;   rdat_q <= rdat_d;   wdat_q <= wdat_d;
      rdmode_q <= rdmode_d;   load_q <= load_d;   cpsrc_q <= cpsrc_d;   stat_q <= stat_d;
      pcnt_q <= pcnt_d;   lrow_q <= lrow_d;   srow_q <= srow_d;   ready_q <= ready_d;
      rdv_q <= rdv_d;   rsp_q <= rsp_d;   pin_q <= pin_d;
    end
  end

  assign cmd_ready = ready_q;
  assign rd_valid  = rdv_q;
  assign rd_data   = rdat_q;
  assign rsp       = rsp_q;
  assign pins      = pin_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_we_pulse;
    !pin_q.we_n [*3] ##1 pin_q.we_n;
  endsequence
  sequence s_rd_pulse;
    !pin_q.read_strobe_n [*3] ##1 pin_q.read_strobe_n;
  endsequence

  a_addr_count: assert property (st_q == S_ADDR && st_d != S_ADDR |-> acnt_d == nadr)
    else $error("wrong number of address cycles");
  a_read_confirm: assert property (st_q == S_CMD2 && cur_q.op == OP_READ && bend
                                   |-> pin_q.dq_o == CB_READ2)
    else $error("page read confirm byte wrong");
  a_rd_strobe: assert property ($fell(pin_q.read_strobe_n) |-> ##0 s_rd_pulse)
    else $error("read strobe width wrong");
  a_we_strobe: assert property ($fell(pin_q.we_n) |-> ##0 s_we_pulse)
    else $error("write strobe width wrong");
  a_partial_limit: assert property (pcnt_q <= PART_MAX)
    else $error("too many partial programs");
  a_page_order: assert property (accept && st_d == S_CMD1 && cmd.op == OP_PROG && pcnt_q != 3'h0 &&
                                 cmd.row[16:PAGE_BITS] == lrow_q[16:PAGE_BITS]
                                 |-> cmd.row[PAGE_BITS-1:0] >= lrow_q[PAGE_BITS-1:0])
    else $error("program page order descending");
  a_plane_match: assert property (st_q == S_CMD1 && cur_q.op == OP_CPPROG
                                  |-> cur_q.row[PLANE_BIT] == srow_q[PLANE_BIT])
    else $error("copy crosses planes");
  a_copy_confirm: assert property (st_q == S_CMD2 && cur_q.op == OP_CPREAD ##1 bend
                                   |-> pin_q.dq_o == CB_CPREAD2)
    else $error("copy read confirm byte wrong");
  a_confirm_load: assert property (st_q == S_IDLE && st_d == S_CMD1 && cmd.op == OP_CONFIRM
                                   |-> load_q)
    else $error("confirm without loaded data");
  a_id_zero: assert property (st_q == S_ADDR && cur_q.op == OP_ID
                              |=> pin_q.dq_o == ID_ADDR && pin_q.ale)
    else $error("id address not zero");
  a_no_strobe_busy: assert property (st_q == S_BUSY |=> pin_q.read_strobe_n && pin_q.we_n)
    else $error("strobe during busy");

endmodule : nph_host

// ### inc/nph_pkg.sv
package nph_pkg;

  typedef logic [16:0] nph_tmr_t;

  // clock and pin timing
  localparam int       CLK_MHZ           = 100;
  localparam int       T_STROBE_NS       = 30;
  localparam int       T_WHR_NS          = 60;
  localparam int       T_WB_NS           = 100;
  localparam int       PAGE_LOAD_TIME_US = 40;
  localparam nph_tmr_t STB_CYC  = nph_tmr_t'((T_STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam nph_tmr_t WHR_CYC  = nph_tmr_t'((T_WHR_NS * CLK_MHZ + 999) / 1000);
  localparam nph_tmr_t WB_CYC   = nph_tmr_t'((T_WB_NS * CLK_MHZ + 999) / 1000);
  localparam nph_tmr_t LOAD_CYC = nph_tmr_t'(PAGE_LOAD_TIME_US * CLK_MHZ);

  // array geometry and counts
  localparam int         PAGE_BYTES = 2112;
  localparam logic [2:0] ADDR_CYC   = 3'h5;
  localparam logic [2:0] COL_CYC    = 3'h2;
  localparam logic [2:0] ID_CYC     = 3'h1;
  localparam logic [11:0] ID_BYTES  = 12'h005;
  localparam logic [2:0] PART_MAX   = 3'h4;
  localparam int         PAGE_BITS  = 6;
  localparam int         PLANE_BIT  = 6;

  // command bytes
  localparam logic [7:0] CB_READ1   = 8'h00;
  localparam logic [7:0] CB_READ2   = 8'h30;
  localparam logic [7:0] CB_CPREAD2 = 8'h35;
  localparam logic [7:0] CB_ROUT1   = 8'h05;
  localparam logic [7:0] CB_ROUT2   = 8'he0;
  localparam logic [7:0] CB_PROG1   = 8'h80;
  localparam logic [7:0] CB_RIN     = 8'h85;
  localparam logic [7:0] CB_PROG2   = 8'h10;
  localparam logic [7:0] CB_STATUS  = 8'h70;
  localparam logic [7:0] CB_ID      = 8'h90;
  localparam logic [7:0] CB_RESET   = 8'hff;
  localparam logic [7:0] ID_ADDR    = 8'h00;

  typedef enum logic [3:0] {
    OP_READ, OP_CPREAD, OP_ROUT, OP_PROG, OP_CPPROG,
    OP_RIN, OP_CONFIRM, OP_STATUS, OP_ID, OP_RESET
  } nph_op_t;

  typedef struct packed {
    nph_op_t     op;
    logic [11:0] col;
    logic [16:0] row;
    logic [11:0] len;
  } nph_cmd_t;

  typedef struct packed {
    logic       done;
    logic       err;
    logic       fail;
    logic [7:0] status;
  } nph_rsp_t;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic       dq_oe;
    logic [7:0] dq_o;
  } nph_pins_t;

endpackage : nph_pkg

// ### hw/nph_fifo.sv
module nph_fifo
  import nph_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,  // system clock
  input  wire logic             rst,       // synchronous reset
  input  wire logic             in_valid,  // producer has a word
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word in
  output logic                  out_valid, // word available
  input  wire logic             out_ready, // consumer takes the word
  output logic      [WIDTH-1:0] out_data   // word out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  always_comb begin
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    in_ready  = cnt_q != (AW+1)'(DEPTH);
    out_valid = cnt_q != '0;
    out_data  = mem_q[rp_q];
    mem_d     = mem_q;
    wp_d      = wp_q;
    rp_d      = rp_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_fifo_bound: assert property (cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  a_fifo_full_stall: assert property (cnt_q == (AW+1)'(DEPTH) && !pop |=> !in_ready)
    else $error("full fifo offered room");

endmodule : nph_fifo

// ### bench/nph_flash_model.sv
module nph_flash_model
  import nph_pkg::*;
#(
  parameter int         LOAD_NS  = 2000,
  parameter int         PROG_NS  = 1000,
  parameter int         RST_NS   = 500,
  parameter logic [7:0] MAKER_ID = 8'h3c, // arbitrary value
  parameter logic [7:0] DEV_ID   = 8'h5e, // arbitrary value
  parameter logic [7:0] ID3      = 8'h00,
  parameter logic [7:0] ID4      = 8'h15,
  parameter logic [7:0] ID5      = 8'h04
) (
  input  wire nph_pins_t  pins, // host pin drive
  output logic      [7:0] dq,   // data toward host
  output logic            rb_n  // ready high, busy low
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [39:0] ID_ALL = {MAKER_ID, DEV_ID, ID3, ID4, ID5};

  logic [7:0]  arr [4][PAGE_BYTES];
  logic [7:0]  pg [PAGE_BYTES];
  logic [7:0]  last;
  logic [16:0] row;
  logic [11:0] col;
  logic [1:0]  mode; // 0 page data, 1 status, 2 id
  logic        fail;
  logic        load_open;
  int          na;
  int          idn;

  initial begin
    foreach (arr[p, i]) arr[p][i] = 8'hff;
    rb_n = 1'b1;
    dq = 8'hff;
    last = 8'h00;
    mode = 2'd0;
    fail = 1'b0;
    load_open = 1'b0;
    na = 0;
    idn = 0;
    row = '0;
    col = '0;
  end

  task automatic go_busy(input int ns);
    rb_n = 1'b0;
    rb_n <= #(ns + 2) 1'b1; // release away from the host's sampling edge
  endtask : go_busy

  task automatic exec(input logic [7:0] c);
    if (rb_n === 1'b0 && c != CB_STATUS && c != CB_RESET) return;
    na = 0;
    case (c)
      CB_READ1: load_open = 1'b0;
      CB_READ2, CB_CPREAD2: begin
        pg = arr[row[1:0]];
        mode = 2'd0;
        go_busy(LOAD_NS);
      end
      CB_PROG1: begin
        foreach (pg[i]) pg[i] = 8'hff;
        load_open = 1'b1;
        mode = 2'd0;
      end
      CB_RIN: load_open = 1'b1;
      CB_PROG2: if (load_open) begin
        fail = 1'b0;
        foreach (pg[i]) begin
          arr[row[1:0]][i] = arr[row[1:0]][i] & pg[i];
          if ((~pg[i] & arr[row[1:0]][i]) != 8'h00) fail = 1'b1;
        end
        load_open = 1'b0;
        mode = 2'd1;
        go_busy(PROG_NS);
      end
      CB_STATUS: mode = 2'd1;
      CB_ID: begin
        mode = 2'd2;
        idn = 0;
      end
      CB_RESET: begin
        load_open = 1'b0;
        fail = 1'b0;
        mode = 2'd0;
        go_busy(RST_NS);
      end
      default: mode = 2'd0;
    endcase
  endtask : exec

  always @(posedge pins.we_n) begin
    if (pins.ce_n === 1'b0 && pins.cle === 1'b1) exec(pins.dq_o);
    else if (pins.ce_n === 1'b0 && pins.ale === 1'b1) begin
      case (na)
        0: col[7:0] = pins.dq_o;
        1: col[11:8] = pins.dq_o[3:0];
        2: row[7:0] = pins.dq_o;
        3: row[15:8] = pins.dq_o;
        default: row[16] = pins.dq_o[0];
      endcase
      na = na + 1;
    end else if (pins.ce_n === 1'b0 && load_open) begin
      pg[col] = pins.dq_o;
      col = col + 12'h001;
    end
  end

  always @(negedge pins.read_strobe_n) begin
    if (pins.ce_n === 1'b0) begin
      case (mode)
        2'd1: last = {1'b1, rb_n, 5'h00, fail};
        2'd2: last = (idn < 5) ? ID_ALL[8*(4-idn) +: 8] : 8'h00;
        default: last = pg[col];
      endcase
      if (mode == 2'd2) idn = idn + 1;
      else if (mode == 2'd0) col = col + 12'h001;
      dq = last;
    end
  end

  // released bus must not look like held data
  always @(posedge pins.read_strobe_n) dq = ~last;
endmodule : nph_flash_model

// ### bench/nph_host_bench.sv
module nph_host_bench
  import nph_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] MK  = 8'h3c; // arbitrary value
  localparam logic [7:0] DV  = 8'h5e; // arbitrary value
  // one chip, two-level cells, one page at once, no interleave, no cache
  localparam logic [7:0] ID3 = {1'b0, 1'b0, 2'b00, 2'b00, 2'b00};
  // 50/30ns access, x8, 128KB block, 16 spare, 2KB page
  localparam logic [7:0] ID4 = {1'b0, 1'b0, 2'b01, 1'b0, 1'b1, 2'b01};
  // 64Mb plane, two planes
  localparam logic [7:0] ID5 = {1'b0, 3'b000, 2'b01, 2'b00};

  logic       core_clk, rst, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, rb_n;
  logic [7:0] wr_data, rd_data, fl_dq, dq_bus;
  nph_cmd_t   cmd;
  nph_rsp_t   rsp;
  nph_pins_t  pins;
  logic [7:0] rx[$];
  logic [7:0] pat [4];
  logic       last_err;
  int         n_fail, cmp_count;

  nph_host #(.BUSY_LIMIT(200), .FIFO_DEPTH(4)) dut_u (
    .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
    .rd_data(rd_data), .rsp(rsp), .pins(pins), .dq_i(dq_bus), .rb_n(rb_n)
  );
  nph_flash_model #(.MAKER_ID(MK), .DEV_ID(DV), .ID3(ID3), .ID4(ID4), .ID5(ID5)) flash_u (
    .pins(pins), .dq(fl_dq), .rb_n(rb_n)
  );
  assign dq_bus = pins.dq_oe ? pins.dq_o : fl_dq;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) if (!rst && rd_valid === 1'b1) rx.push_back(rd_data);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_cmd(input nph_op_t op, input logic [11:0] c, input logic [16:0] r,
                        input logic [11:0] n);
    int k;
    k = 0;
    rx.delete();
    cmd = '{op: op, col: c, row: r, len: n};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && k < 9000) begin
      @(posedge core_clk);
      #1 k = k + 1;
    end
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    while (rsp.done !== 1'b1 && k < 9000) begin
      @(posedge core_clk);
      #1 k = k + 1;
    end
    last_err = rsp.err;
    if (k >= 9000) n_fail++;
  endtask : do_cmd

  task automatic push(input logic [7:0] b);
    wr_data = b;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
  endtask : push

  task automatic t_id();
    do_cmd(OP_ID, 12'h000, 17'h00000, 12'h005);
    check(8'(rx.size()), 8'h05);
    check(rx[0], MK);
    check(rx[1], DV);
    check(rx[2], ID3);
    check(rx[3], ID4);
    check(rx[4], ID5);
    $display("test id done");
  endtask : t_id

  task automatic t_prog();
    foreach (pat[i]) push(pat[i]);
    wr_valid = 1'b0;
    check(wr_ready, 1'b0);
    do_cmd(OP_PROG, 12'h000, 17'h00001, 12'h004);
    check(last_err, 1'b0);
    do_cmd(OP_CONFIRM, 12'h000, 17'h00000, 12'h000);
    check(last_err, 1'b0);
    check(rsp.status[6], 1'b1);
    check(rsp.fail, 1'b0);
    $display("test program done");
  endtask : t_prog

  task automatic t_read();
    do_cmd(OP_READ, 12'h000, 17'h00001, 12'h004);
    check(8'(rx.size()), 8'h04);
    foreach (pat[i]) check(rx[i], pat[i]);
    do_cmd(OP_ROUT, 12'h002, 17'h00001, 12'h002);
    check(rx[0], pat[2]);
    check(rx[1], pat[3]);
    do_cmd(OP_ROUT, 12'h001, 17'h00001, 12'h001);
    check(rx[0], pat[1]);
    $display("test read done");
  endtask : t_read

  task automatic t_refuse();
    do_cmd(OP_CONFIRM, 12'h000, 17'h00000, 12'h000);
    check(last_err, 1'b1);
    do_cmd(OP_PROG, 12'h000, 17'h00000, 12'h001);
    check(last_err, 1'b1);
    do_cmd(OP_RIN, 12'h000, 17'h00000, 12'h001);
    check(last_err, 1'b1);
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_partial();
    for (int i = 0; i < 5; i++) begin
      if (i < 4) push(8'hff << i);
      wr_valid = 1'b0;
      do_cmd(OP_PROG, 12'h000, 17'h00002, 12'h001);
      check(last_err, 8'(i == 4));
      if (i < 4) do_cmd(OP_CONFIRM, 12'h000, 17'h00000, 12'h000);
      check(rsp.fail, 1'b0);
    end
    do_cmd(OP_READ, 12'h000, 17'h00002, 12'h001);
    check(rx[0], 8'hf8);
    $display("test partial done");
  endtask : t_partial

  task automatic t_copy();
    do_cmd(OP_CPREAD, 12'h000, 17'h00001, 12'h004);
    check(rx[3], pat[3]);
    do_cmd(OP_CPPROG, 12'h000, 17'h00043, 12'h000);
    check(last_err, 1'b1);
    do_cmd(OP_CPPROG, 12'h000, 17'h00003, 12'h000);
    check(last_err, 1'b0);
    push(8'h77);
    wr_valid = 1'b0;
    do_cmd(OP_RIN, 12'h001, 17'h00003, 12'h001);
    check(last_err, 1'b0);
    do_cmd(OP_CONFIRM, 12'h000, 17'h00000, 12'h000);
    check(rsp.status[0], 1'b0);
    do_cmd(OP_READ, 12'h000, 17'h00003, 12'h004);
    check(rx[0], pat[0]);
    check(rx[1], 8'h77);
    $display("test copy done");
  endtask : t_copy

  task automatic t_reset();
    do_cmd(OP_RESET, 12'h000, 17'h00000, 12'h000);
    check(last_err, 1'b0);
    do_cmd(OP_ROUT, 12'h000, 17'h00001, 12'h001);
    check(last_err, 1'b1);
    do_cmd(OP_READ, 12'h002, 17'h00001, 12'h001);
    check(rx[0], pat[2]);
    do_cmd(OP_STATUS, 12'h000, 17'h00000, 12'h001);
    check(rx[0], 8'hc0);
    check(rsp.status, 8'hc0);
    do_cmd(OP_ROUT, 12'h000, 17'h00001, 12'h001);
    check(last_err, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #200_000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    n_fail = 0;
    cmp_count = 0;
    pat = '{8'ha5, 8'h3c, 8'h0f, 8'h96};
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    t_id();
    t_prog();
    t_read();
    t_refuse();
    t_partial();
    t_copy();
    t_reset();
    tally_and_finish();
  end
endmodule : nph_host_bench
